// >>> inc/hpl_pkg.sv
package hpl_pkg;
  localparam int          ADDR_W        = 10;
  localparam int          DATA_W        = 8;
  localparam logic [1:0]  MODE_STROBE   = 2'h0;
  localparam logic [1:0]  MODE_DSTROBE  = 2'h1;
  localparam logic [1:0]  MODE_SPI      = 2'h2;
  localparam logic [7:0]  EE_READ_CMD   = 8'h03;
  localparam int          CMD_BITS      = 16;
  localparam logic [2:0]  STRAP_SETTLE  = 3'h4;
  localparam int          SYS_CLK_HZ    = 20_000_000;
  localparam int          SCK_HZ        = 1_250_000;
  localparam int          SCK_HALF_CYC  = SYS_CLK_HZ / (2 * SCK_HZ);

  // Everything that arrives from outside the clock domain.
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] data;
    logic              cs_n;
    logic              rd_n;
    logic              wr_n;
    logic              strap_sel;
    logic [1:0]        mode;
    logic              phase;
  } hpl_pins_t;

  typedef struct packed {
    logic first_bit_order_select;
    logic scrambler_disable_strap;
    logic laps_encap_select;
  } hpl_cfg_t;

  localparam hpl_cfg_t CFG_RESET = '0;

  typedef enum logic [1:0] {
    SP_IDLE   = 2'b00,
    SP_SHIFT  = 2'b01,
    SP_FINISH = 2'b10,
    SP_DONE   = 2'b11
  } hpl_spi_state_t;
endpackage : hpl_pkg

// >>> src/hpl_host_port.sv
`timescale 1ns/100ps
// Contract
// - Host address is ten bits, bit 0 least significant; all ten bits decode.
// - All eight data lines float while reset is active, and while chip select is high outside SPI mode.
// - Hardware mode: address 0 picks first bit order, 0 MSB first, 1 LSB.
// - Hardware mode: address 1 high disables the scrambler on both paths.
// - Hardware mode: address 2 high selects X.86, low selects HDLC.
// - SPI mode drives instruction and address to the EEPROM on data bit 0.
// - Master-out changes on rising edge when phase high, falling when low.
// - Master-in sampled on falling edge when phase high, rising when low.
// - Software mode select: 00 strobes, 01 data strobe, 10 SPI, 11 reserved.
// - Chip select must be low for accesses; strobes ignored while it is high.
// - Strobe mode drives addressed register while read strobe and select low.
// - Strobe mode stores the data bus on the write strobe rising edge.
module hpl_host_port #(
  parameter int               REG_COUNT     = 16,
  parameter int               SCK_HALF      = hpl_pkg::SCK_HALF_CYC,
  parameter logic [7:0]       EE_START_ADDR = 8'h00
) (
  input  wire logic                        clk,
  input  wire logic                        reset,
  input  wire logic [hpl_pkg::ADDR_W-1:0]  addr_pins,
  input  wire logic [hpl_pkg::DATA_W-1:0]  data_in,
  output logic      [hpl_pkg::DATA_W-1:0]  data_out,
  output logic      [hpl_pkg::DATA_W-1:0]  data_oe,
  input  wire logic                        chip_select_n,
  input  wire logic                        read_or_data_strobe_n,
  input  wire logic                        write_or_read_sel_n,
  input  wire logic                        strap_config_select,
  input  wire logic [1:0]                  host_port_mode_select,
  input  wire logic                        serial_clock_phase,
  output logic                             eeprom_cs_n,
  output hpl_pkg::hpl_cfg_t                strap_cfg,
  output logic                             strap_valid,
  output logic                             load_done,
  output logic [REG_COUNT-1:0][7:0]        reg_file
);
  import hpl_pkg::*;

  localparam int TOTAL = CMD_BITS + 8 * REG_COUNT;
  localparam int CW    = $clog2(TOTAL + 1);
  localparam int DW    = $clog2(SCK_HALF);
  localparam int IW    = $clog2(REG_COUNT);

  // Full ten-bit decode: only the low REG_COUNT addresses exist.
  function automatic logic reg_hit(input logic [ADDR_W-1:0] a);
    reg_hit = (32'(a) < REG_COUNT);
  endfunction : reg_hit

  // Pin 0 lands in the first, most significant field, so the pin order is reversed here.
  function automatic hpl_cfg_t strap_map(input logic [2:0] a);
    strap_map = hpl_cfg_t'({a[0], a[1], a[2]});
  endfunction : strap_map

  hpl_pins_t      raw, s1_q, s2_q, s3_q, filt_q, prev_q;
  hpl_cfg_t       cfg_q;
  logic [1:0]     mode_q;
  logic           hw_q, valid_q, capture;
  logic [2:0]     settle_q;
  logic [7:0]     rd_data_q;
  hpl_spi_state_t state_q;
  logic [DW-1:0]  div_q;
  logic           sck_q, mosi_q, cs_n_q, done_q, tick, sck_d, upd_edge, smp_edge, start;
  logic [15:0]    tx_q;
  logic [7:0]     rx_q;
  logic [CW-1:0]  bit_q;
  logic           wr_fire, host_rd, spi_mode, host_on, last_bit, byte_end;
  logic [IW-1:0]  byte_idx;

  assign raw = '{addr: addr_pins, data: data_in, cs_n: chip_select_n, rd_n: read_or_data_strobe_n,
                 wr_n: write_or_read_sel_n, strap_sel: strap_config_select,
                 mode: host_port_mode_select, phase: serial_clock_phase};

  // Three-stage synchroniser; a bit moves only once stages two and three agree.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      s1_q   <= '1;  // Stages idle high like the strobes, so no false edge follows reset.
      s2_q   <= '1;
      s3_q   <= '1;
      filt_q <= '1;
      prev_q <= '1;
    end else begin
      s1_q   <= raw;
      s2_q   <= s1_q;
      s3_q   <= s2_q;
      filt_q <= (s2_q & ~(s2_q ^ s3_q)) | (filt_q & (s2_q ^ s3_q));
      prev_q <= filt_q;
    end
  end

  // strap capture after release
  // The settle count covers the synchroniser so the latched straps are clean.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      settle_q <= '0;
      valid_q  <= 1'b0;
      cfg_q    <= CFG_RESET;
      hw_q     <= 1'b0;
      mode_q   <= MODE_STROBE;
    end else if (!valid_q) begin
      settle_q <= settle_q + 3'h1;
      if (capture) begin
        valid_q <= 1'b1;
        hw_q    <= filt_q.strap_sel;
        mode_q  <= filt_q.mode;
        cfg_q   <= filt_q.strap_sel ? strap_map(filt_q.addr[2:0]) : CFG_RESET;
      end
    end
  end

  assign capture  = !valid_q && (settle_q == STRAP_SETTLE);
  assign host_on  = valid_q && !hw_q && (mode_q == MODE_STROBE || mode_q == MODE_DSTROBE);
  assign spi_mode = valid_q && !hw_q && (mode_q == MODE_SPI);

  // strobe edge write
  // Both strobe styles commit on the rising edge of the strobe that ends the cycle.
  always_comb begin
    if (mode_q == MODE_STROBE)
      wr_fire = host_on && !filt_q.cs_n && filt_q.wr_n && !prev_q.wr_n;
    else
      wr_fire = host_on && !filt_q.cs_n && filt_q.rd_n && !prev_q.rd_n && !prev_q.wr_n;
  end

  // read drive from live pins
  // Enable follows the raw pins so the bus floats at once when select rises.
  assign host_rd = !reset && host_on && !chip_select_n && !read_or_data_strobe_n &&
                   (mode_q == MODE_STROBE || write_or_read_sel_n);

  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      rd_data_q <= '0;
    else
      rd_data_q <= reg_hit(filt_q.addr) ? reg_file[IW'(filt_q.addr)] : 8'h00;
  end

  // serial pins share the data bus
  always_comb begin
    data_oe  = '0;
    data_out = rd_data_q;
    if (spi_mode && !reset) begin
      data_oe  = 8'h05;
      data_out = {5'h00, sck_q, 1'b0, mosi_q};
    end else if (host_rd) begin
      data_oe  = 8'hff;
    end
  end

  assign tick     = (state_q == SP_SHIFT || state_q == SP_FINISH) && (32'(div_q) == SCK_HALF - 1);
  assign sck_d    = ~sck_q;
  assign upd_edge = tick && state_q == SP_SHIFT && (filt_q.phase ? sck_d : ~sck_d);
  assign smp_edge = tick && state_q == SP_SHIFT && (filt_q.phase ? ~sck_d : sck_d);
  assign start    = spi_mode && state_q == SP_IDLE;
  assign last_bit = (32'(bit_q) == TOTAL - 1);
  assign byte_end = (32'(bit_q) >= CMD_BITS) && (bit_q[2:0] == 3'h7);
  assign byte_idx = IW'((32'(bit_q) - CMD_BITS) >> 3);

  // EEPROM loader sequencing; one read instruction pulls the whole register file.
  always_ff @(posedge clk or posedge reset) begin
    if (reset) begin
      state_q <= SP_IDLE;
      div_q   <= '0;
      sck_q   <= 1'b0;
      mosi_q  <= 1'b0;
      cs_n_q  <= 1'b1;
      tx_q    <= '0;
      rx_q    <= '0;
      bit_q   <= '0;
      done_q  <= 1'b0;
    end else begin
      div_q <= tick ? '0 : (state_q == SP_SHIFT || state_q == SP_FINISH) ? div_q + 1'b1 : '0;
      unique case (state_q)
        SP_IDLE: begin
          if (start) begin
            state_q <= SP_SHIFT;
            cs_n_q  <= 1'b0;
            // Falling-update phase needs bit one on the line before the first rise.
            mosi_q  <= EE_READ_CMD[7];
            tx_q    <= filt_q.phase ? {EE_READ_CMD, EE_START_ADDR} : {EE_READ_CMD[6:0], EE_START_ADDR, 1'b0};
          end
        end
        SP_SHIFT: begin
          if (tick) sck_q <= sck_d;
          if (upd_edge) begin
            mosi_q <= tx_q[15];
            tx_q   <= {tx_q[14:0], 1'b0};
          end
          if (smp_edge) begin
            rx_q  <= {rx_q[6:0], filt_q.data[1]};
            bit_q <= bit_q + 1'b1;
            if (last_bit) state_q <= SP_FINISH;
          end
        end
        SP_FINISH: begin
          if (tick) begin
            sck_q   <= 1'b0;
            cs_n_q  <= 1'b1;
            done_q  <= 1'b1;
            state_q <= SP_DONE;
          end
        end
        SP_DONE: begin
          cs_n_q <= 1'b1;
        end
      endcase
    end
  end

  // Register storage; loader and host never run in the same mode.
  always_ff @(posedge clk or posedge reset) begin
    if (reset)
      reg_file <= '0;
    else if (smp_edge && byte_end)
      reg_file[byte_idx] <= {rx_q[6:0], filt_q.data[1]};
    else if (wr_fire && reg_hit(filt_q.addr))
      reg_file[IW'(filt_q.addr)] <= filt_q.data;
  end

  assign eeprom_cs_n = cs_n_q;
  assign strap_cfg   = cfg_q;
  assign strap_valid = valid_q;
  assign load_done   = done_q;

  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  property p_float_cs;
    chip_select_n && !spi_mode |-> data_oe == 8'h00;
  endproperty
  a_float_cs: assert property (p_float_cs) else $error("Data bus driven while deselected.");

  property p_straps;
    capture |=> cfg_q == (hw_q ? strap_map($past(filt_q.addr[2:0])) : CFG_RESET);
  endproperty
  a_straps: assert property (p_straps) else $error("Strap settings differ from sampled pins.");

  property p_hold;
    valid_q |=> valid_q && $stable(cfg_q) && $stable(mode_q);
  endproperty
  a_hold: assert property (p_hold) else $error("Strap settings changed after capture.");

  property p_mosi;
    state_q == SP_SHIFT && $changed(mosi_q) |-> $past(upd_edge);
  endproperty
  a_mosi: assert property (p_mosi) else $error("Master-out moved off its update edge.");

  property p_sample;
    smp_edge |-> (filt_q.phase ? sck_q : !sck_q);
  endproperty
  a_sample: assert property (p_sample) else $error("Master-in sampled on the wrong edge.");

  sequence s_load_start;
    start ##1 state_q == SP_SHIFT;
  endsequence
  property p_cs_low;
    s_load_start |-> !eeprom_cs_n [*8];
  endproperty
  a_cs_low: assert property (p_cs_low) else $error("EEPROM select rose during a transaction.");

  property p_mosi_pin;
    spi_mode |-> data_oe[0] && data_out[0] == mosi_q && data_out[2] == sck_q;
  endproperty
  a_mosi_pin: assert property (p_mosi_pin) else $error("Serial pins not on the data bus.");

  sequence s_write;
    wr_fire && reg_hit(filt_q.addr) && !smp_edge;
  endsequence
  property p_write;
    s_write |=> reg_file[IW'($past(filt_q.addr))] == $past(filt_q.data);
  endproperty
  a_write: assert property (p_write) else $error("Host write not stored.");

  property p_ignore;
    filt_q.cs_n |-> !wr_fire;
  endproperty
  a_ignore: assert property (p_ignore) else $error("Strobe accepted while deselected.");

  property p_decode;
    wr_fire && !reg_hit(filt_q.addr) && !spi_mode |=> $stable(reg_file);
  endproperty
  a_decode: assert property (p_decode) else $error("Unmapped write changed a register.");

  property p_read;
    host_rd |-> data_oe == 8'hff && data_out == rd_data_q;
  endproperty
  a_read: assert property (p_read) else $error("Read cycle not driving register data.");
endmodule : hpl_host_port

// >>> tb/hpl_eeprom_model.sv
`timescale 1ns/100ps
// Serial memory on the far side of the loader; answers with a fixed image.
module hpl_eeprom_model #(
  parameter logic [15:0] IMAGE = 16'h5ac3
) (
  input  wire logic        sck,
  input  wire logic        mosi,
  input  wire logic        cs_n,
  input  wire logic        phase,
  output logic             miso,
  output logic [15:0]      cmd_q
);
  int upd_n;
  int smp_n;
  int j;

  initial begin
    miso  = 1'b0;
    upd_n = 0;
    smp_n = 0;
    cmd_q = '0;
  end

  // A new frame restarts both bit counts.
  always @(negedge cs_n) begin
    upd_n = 0;
    smp_n = 0;
  end

  // A released line shows the inverse, so a stale bit can never pass.
  always @(posedge cs_n) miso <= ~miso;

  // MSB first, shifted on the update edge
  always @(sck) begin
    if (!cs_n && sck == phase) begin
      upd_n++;
      j = upd_n - (phase ? 17 : 16);
      miso <= (j >= 0 && j < 16) ? IMAGE[15-j] : ~miso;
    end else if (!cs_n && smp_n < 16) begin
      cmd_q <= {cmd_q[14:0], mosi};
      smp_n++;
    end
  end
endmodule : hpl_eeprom_model

// >>> tb/tb_host_port_spi_loader_straps.sv
`timescale 1ns/100ps
module tb_host_port_spi_loader_straps;
  import hpl_pkg::*;
  typedef struct {
    string      nm;
    int         k;
    logic [7:0] v;
  } hpl_note_t;
  localparam logic [15:0] IMAGE = 16'h5ac3;
  logic              clk, reset, cs_n, rd_n, wr_n, strap, phase, probe, miso;
  logic              eeprom_cs_n, strap_valid, load_done;
  logic [ADDR_W-1:0] addr;
  logic [DATA_W-1:0] host_d, data_in, data_out, data_oe, ext, seen, d0;
  logic [1:0]        mode;
  hpl_cfg_t          strap_cfg;
  logic [1:0][7:0]   reg_file;
  logic [15:0]       cmd_q;
  hpl_note_t         q[$];
  hpl_note_t         e;
  int                fails, n_checks, seed;

  // The pin shows the device's drive where enabled, else the far parties.
  assign ext     = (mode == MODE_SPI) ? {host_d[7:2], miso, host_d[0]} : host_d;
  assign data_in = (data_oe & data_out) | (~data_oe & ext);

  // The half period must exceed the four-clock master-in synchroniser delay.
  hpl_host_port #(.REG_COUNT(2), .SCK_HALF(6)) uut (
    .clk(clk), .reset(reset), .addr_pins(addr), .data_in(data_in), .data_out(data_out),
    .data_oe(data_oe), .chip_select_n(cs_n), .read_or_data_strobe_n(rd_n),
    .write_or_read_sel_n(wr_n), .strap_config_select(strap), .host_port_mode_select(mode),
    .serial_clock_phase(phase), .eeprom_cs_n(eeprom_cs_n), .strap_cfg(strap_cfg),
    .strap_valid(strap_valid), .load_done(load_done), .reg_file(reg_file));

  hpl_eeprom_model #(.IMAGE(IMAGE)) mem (.sck(data_oe[2] & data_out[2]), .mosi(data_out[0]),
    .cs_n(eeprom_cs_n), .phase(phase), .miso(miso), .cmd_q(cmd_q));

  // Free-running system clock.
  initial begin
    clk = 1'b0;
    forever #25 clk = ~clk;
  end

  task automatic check(input string nm, input logic [7:0] exp, input logic [7:0] got);
    n_checks++;
    if (got !== exp) begin
      fails++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, got);
    end
  endtask : check

  // Each probed edge retires the oldest note against the live outputs.
  always @(posedge clk) begin
    if (probe === 1'b1 && q.size() > 0) begin
      e = q.pop_front();
      case (e.k)
        0: seen = data_out;
        1: seen = data_oe;
        2: seen = {5'h0, strap_cfg};
        3: seen = {7'h0, eeprom_cs_n};
        4: seen = reg_file[0];
        5: seen = reg_file[1];
        6: seen = cmd_q[15:8];
        default: seen = cmd_q[7:0];
      endcase
      check(e.nm, e.v, seen);
    end
  end

  task automatic note(input string nm, input int k, input logic [7:0] v);
    q.push_back('{nm, k, v});
    probe <= 1'b1;
    @(posedge clk);
    probe <= 1'b0;
    @(posedge clk);
  endtask : note

  // Bounded wait; a flag that never rises counts as a mismatch.
  task automatic wait_hi(ref logic s, input int lim);
    int i;
    for (i = 0; i < lim && s !== 1'b1; i++) @(negedge clk);
    if (s !== 1'b1) fails++;
    @(posedge clk);
  endtask : wait_hi

  // Select and read strobe are held low during reset, the worst case for a floating bus.
  task automatic restart(input logic hw, input logic [1:0] m, input logic ph, input logic [9:0] a);
    reset <= 1'b1;
    strap <= hw;
    mode <= m;
    phase <= ph;
    addr <= a;
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    wr_n <= 1'b1;
    repeat (10) @(posedge clk);
    note("oe_in_reset", 1, 8'h00);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    @(posedge clk);
    reset <= 1'b0;
    wait_hi(strap_valid, 40);
  endtask : restart

  // select held at sel_n for the whole access
  task automatic wr(input logic [9:0] a, input logic [7:0] d, input logic sel_n);
    addr <= a;
    host_d <= d;
    cs_n <= sel_n;
    rd_n <= (mode == MODE_STROBE) ? 1'b1 : 1'b0;
    wr_n <= 1'b0;
    repeat (5) @(posedge clk);
    if (mode == MODE_STROBE) wr_n <= 1'b1;
    else rd_n <= 1'b1;
    repeat (6) @(posedge clk);
    wr_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (5) @(posedge clk);
  endtask : wr

  task automatic rd(input logic [9:0] a, input logic [7:0] x, input logic sel_n);
    addr <= a;
    cs_n <= sel_n;
    rd_n <= 1'b0;
    wr_n <= 1'b1;
    repeat (7) @(posedge clk);
    note("oe_on_read", 1, sel_n ? 8'h00 : 8'hff);
    if (!sel_n) note("read_data", 0, x);
    rd_n <= 1'b1;
    cs_n <= 1'b1;
    repeat (5) @(posedge clk);
    note("oe_after_read", 1, 8'h00);
  endtask : rd

  task automatic print_verdict;
    $display("checks %0d mismatches %0d", n_checks, fails);
    if (fails == 0 && n_checks > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : print_verdict

  // The run needs under 2000 cycles; the margin covers a slow load.
  initial begin
    repeat (8000) @(posedge clk);
    fails++;
    print_verdict();
  end

  initial begin
    seed = 32'h6aa3;
    fails = 0;
    n_checks = 0;
    probe = 1'b0;
    {reset, cs_n, rd_n, wr_n, strap, phase} = 6'h3e;
    addr = '0;
    host_d = '0;
    mode = 2'h0;
    // Every strap pattern, then moved pins must not disturb the capture.
    for (int k = 0; k < 8; k++) begin
      restart(1'b1, 2'h0, 1'b0, 10'(k));
      note("straps", 2, {5'h0, k[0], k[1], k[2]});
      addr <= ~10'(k);
      repeat (8) @(posedge clk);
      note("straps_held", 2, {5'h0, k[0], k[1], k[2]});
    end
    $display("strap test done");
    for (int m = 0; m < 2; m++) begin
      restart(1'b0, 2'(m), 1'b0, 10'h000);
      d0 = 8'($random(seed));
      wr(10'h001, d0, 1'b0);
      wr(10'h201, ~d0, 1'b0);
      wr(10'h000, d0, 1'b1);
      note("reg1", 5, d0);
      note("reg0", 4, 8'h00);
      rd(10'h001, d0, 1'b0);
      rd(10'h201, 8'h00, 1'b0);
      rd(10'h001, 8'h00, 1'b1);
      $display("host mode %0d test done", m);
    end
    restart(1'b0, 2'h3, 1'b0, 10'h000);
    wr(10'h001, d0, 1'b0);
    note("reg1_reserved", 5, 8'h00);
    cs_n <= 1'b0;
    rd_n <= 1'b0;
    repeat (6) @(posedge clk);
    note("oe_reserved", 1, 8'h00);
    cs_n <= 1'b1;
    rd_n <= 1'b1;
    repeat (2) @(posedge clk);
    $display("reserved mode test done");
    // serial load in both clock phases
    for (int p = 0; p < 2; p++) begin
      restart(1'b0, MODE_SPI, 1'(p), 10'h000);
      repeat (2) @(posedge clk);
      note("ee_select", 3, 8'h00);
      note("spi_oe", 1, 8'h05);
      wait_hi(load_done, 600);
      note("byte0", 4, IMAGE[15:8]);
      note("byte1", 5, IMAGE[7:0]);
      note("ee_release", 3, 8'h01);
      note("instr", 6, EE_READ_CMD);
      note("ee_addr", 7, 8'h00);
      $display("serial load phase %0d test done", p);
    end
    print_verdict();
  end
endmodule : tb_host_port_spi_loader_straps
